/* File: hdl/overcurrent_idmt_protection.sv */
// Over-current immediate warning and inverse-time thermal trip element
`timescale 1ns/1ps
`include "overcurrent_regs.svh"

module overcurrent_idmt_protection #(
  // Clocks per 10 ms time base tick
  parameter int TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire overcurrent_pkg::amps_t phase_line_a,
  input wire overcurrent_pkg::amps_t phase_line_b,
  input wire overcurrent_pkg::amps_t phase_line_c,
  input wire logic [`ADDR_W-1:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  output logic warn_alarm,
  output logic idmt_alarm,
  output logic shutdown_out,
  output logic elec_trip_out,
  output logic irq
);
  import overcurrent_pkg::*;

  // Time base ticks per multiplier unit of 0.1 s
  // The curve is worked in ticks, so a shortened time base
  // scales every trip time by the same factor
  localparam int TPU = `TMUL_UNIT_NS / `TICK_NS;

  // Highest of three phase currents
  // Ties take the later phase; only the value matters
  function automatic amps_t max3(input amps_t a, input amps_t b, input amps_t c);
    amps_t m;
    m = (a > b) ? a : b;
    m = (m > c) ? m : c;
    return m;
  endfunction

  // Heat that corresponds to unity: trip^2 * multiplier * ticks per unit
  // Each tick adds (imax - trip)^2, so unity is reached after
  // tmul * TPU * (trip / (imax - trip))^2 ticks
  // Widest case stays well inside the 56-bit accumulator
  function automatic heat_t unity(input amps_t it, input amps_t tm);
    heat_t r;
    r = heat_t'(it) * heat_t'(it);
    r = r * heat_t'(tm);
    r = r * heat_t'(TPU);
    return r;
  endfunction

  // Square of the excess current
  // Only meaningful above trip; callers gate on that
  function automatic heat_t excess_sq(input amps_t ia, input amps_t it);
    amps_t d;
    d = ia - it;
    return heat_t'(d) * heat_t'(d);
  endfunction

  // Register file state
  // Configuration is held here and read live by the protection logic
  ctrl_s ctrl_reg, ctrl_next;         // Enables, latch and action
  amps_t trip_reg, trip_next;         // Trip level in amps
  amps_t tmul_reg, tmul_next;         // Time multiplier in 0.1 s
  evt_s mask_reg, mask_next;          // Interrupt mask
  evt_s status_reg, status_next;      // Sticky event bits
  logic clr_reg, clr_next;            // Alarm clear pulse
  logic [31:0] rdata_reg, rdata_next; // Read data, one cycle
  logic irq_reg, irq_next;            // Interrupt level

  // Protection state
  // Everything the thermal element remembers between ticks
  logic [31:0] tick_cnt_reg, tick_cnt_next; // Time base divider
  logic tick_reg, tick_next;                // One-cycle tick
  amps_t imax_reg, imax_next;               // Highest phase current
  heat_t heat_reg, heat_next;               // Thermal accumulator
  heat_e state_reg, state_next;             // Thermal element state
  logic warn_reg, warn_next;                // Immediate warning
  logic idmt_reg, idmt_next;                // Inverse-time alarm
  logic shut_reg, shut_next;                // Shutdown action
  logic elec_reg, elec_next;                // Electrical trip action
  logic over_reg, over_next;                // Current above trip
  evt_s evt_reg, evt_next;                  // Rising events

  // Combinational helpers
  // Recomputed every cycle from the registered state
  logic reach;     // Current at or above trip level
  logic exceed;    // Current strictly above trip level
  heat_t thr;      // Unity heat
  heat_t sum;      // Heat after one overload tick
  heat_t dec;      // Cooling step

  // Bus decode, configuration, sticky status and interrupt
  // Writes land at the strobe edge; reads answer one cycle later
  // and the read data drop back to zero after that cycle
  // The slave never stalls, so strobes may come back to back
  always_comb begin
    // Hold every setting unless a write says otherwise
    ctrl_next = ctrl_reg;
    trip_next = trip_reg;
    tmul_next = tmul_reg;
    mask_next = mask_reg;
    clr_next = 1'b0;
    rdata_next = 32'h0;
    // Writes update configuration
    // Status, state and heat are read-only and ignore writes
    if (bus_wr) begin
      case (bus_addr)
        `OFS_CTRL: begin
          ctrl_next = ctrl_s'(bus_wdata[3:0]);
          clr_next = bus_wdata[`CTRL_CLEAR_BIT];
        end
        `OFS_TRIP: begin
          trip_next = bus_wdata[15:0];
        end
        `OFS_TMUL: begin
          tmul_next = bus_wdata[15:0];
        end
        `OFS_MASK: begin
          mask_next = evt_s'(bus_wdata[2:0]);
        end
        default: begin
          // Unmapped or read-only: ignored
        end
      endcase
    end
    // Read of status clears it, new events still win
    // An event in the clearing cycle is kept, so none is lost
    status_next = status_reg;
    if (bus_rd && bus_addr == `OFS_STATUS) begin
      status_next = 3'h0;
    end
    status_next = status_next | evt_reg;
    // Read data for the next cycle only
    // Narrow fields sit in the low bits, upper bits read zero
    if (bus_rd) begin
      case (bus_addr)
        `OFS_CTRL: begin
          rdata_next = {28'h0, ctrl_reg};
        end
        `OFS_TRIP: begin
          rdata_next = {16'h0, trip_reg};
        end
        `OFS_TMUL: begin
          rdata_next = {16'h0, tmul_reg};
        end
        `OFS_STATUS: begin
          rdata_next = {29'h0, status_reg};
        end
        `OFS_MASK: begin
          rdata_next = {29'h0, mask_reg};
        end
        `OFS_STATE: begin
          rdata_next = {27'h0, state_reg, over_reg, idmt_reg, warn_reg};
        end
        `OFS_HEAT: begin
          rdata_next = heat_reg[`HEAT_RD_LSB+31:`HEAT_RD_LSB];
        end
        default: begin
          rdata_next = 32'h0; // Unmapped reads zero
        end
      endcase
    end
    // Level interrupt while any unmasked bit is set
    // Taken from the next values so irq tracks status exactly
    // Mask changes act at once on pending bits
    irq_next = |(status_next & mask_next);
  end

  // Register file flops, factory values at reset
  // Factory setup: both elements on, electrical trip action,
  // trip level 500 A and a 36.0 s multiplier
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= `RST_CTRL;
      trip_reg <= `RST_TRIP;
      tmul_reg <= `RST_TMUL;
      mask_reg <= `RST_MASK;
      status_reg <= 3'h0;
      clr_reg <= 1'b0;
      rdata_reg <= 32'h0;
      irq_reg <= 1'b0;
    end else begin
      // Take the next values on every edge
      ctrl_reg <= ctrl_next;
      trip_reg <= trip_next;
      tmul_reg <= tmul_next;
      mask_reg <= mask_next;
      status_reg <= status_next;
      clr_reg <= clr_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  // Protection next-state logic
  // Phases are registered once, then compared with the trip level
  // A tick moves the thermal element one step along its curve
  // Disabling the element throws its heat away
  always_comb begin
    // Highest loaded line feeds every comparison
    imax_next = max3(phase_line_a, phase_line_b, phase_line_c);
    // Reaching trip warns, only exceeding it heats
    reach = (imax_reg >= trip_reg);
    exceed = (imax_reg > trip_reg);
    over_next = exceed;
    // Time base divider
    // One-cycle tick every TICK_CYCLES clocks, free running
    // The compare uses >= so a counter upset cannot run away
    tick_next = 1'b0;
    tick_cnt_next = tick_cnt_reg + 32'h1;
    if (tick_cnt_reg >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt_next = 32'h0;
      tick_next = 1'b1;
    end
    // Immediate warning with optional latch
    // Follows the reach condition with no time delay
    // Latch-all keeps it until a clear pulse or warn_en drops
    warn_next = ctrl_reg.warn_en & reach;
    if (ctrl_reg.warn_en && ctrl_reg.latch_all && !clr_reg && warn_reg) begin
      warn_next = 1'b1;
    end
    // Unity heat equals multiplier delay at twice trip current
    // At twice trip the excess equals trip, so unity takes tmul * TPU ticks
    thr = unity(trip_reg, tmul_reg);
    sum = heat_reg + excess_sq(imax_reg, trip_reg);
    // Cooling step, at least one so heat reaches zero
    // Proportional step gives an exponential cooling curve
    dec = heat_reg >> `COOL_SHIFT;
    if (dec == 56'h0 && heat_reg != 56'h0) begin
      dec = 56'h1;
    end
    // Hold heat and state between ticks
    heat_next = heat_reg;
    state_next = state_reg;
    // Thermal element
    // Cold, heating and cooling share one update; tripped waits
    // A disabled element is held cold with no heat
    if (!ctrl_reg.idmt_en) begin
      heat_next = 56'h0;
      state_next = st_cold;
    end else begin
      case (state_reg)
        st_tripped: begin
          // Held until cleared, heat kept for cooling
          // Keeping the heat lets a repeat overload trip quickly
          if (clr_reg) begin
            state_next = st_cool;
          end
        end
        st_cold, st_heat, st_cool: begin
          if (tick_reg) begin
            if (exceed) begin
              // Track the curve while above trip
              // Saturate at unity so cooling starts from a known level
              if (sum >= thr) begin
                heat_next = thr;
                state_next = st_tripped;
              end else begin
                heat_next = sum;
                state_next = st_heat;
              end
            end else begin
              // Follow the cooling curve
              // Cold again once the last of the heat is gone
              heat_next = heat_reg - dec;
              state_next = (heat_reg == dec) ? st_cold : st_cool;
            end
          end
        end
        default: begin
          // Unused code falls back to cold
          state_next = st_cold;
        end
      endcase
    end
    // Alarm and configured action
    // Action is read live, so a changed setting moves the output
    idmt_next = (state_next == st_tripped);
    shut_next = idmt_next & ~ctrl_reg.action;
    elec_next = idmt_next & ctrl_reg.action;
    // Rising edges feed the status register
    // Each event is one cycle long and sets its sticky bit
    evt_next.warn = warn_next & ~warn_reg;
    evt_next.idmt = idmt_next & ~idmt_reg;
    evt_next.over = over_next & ~over_reg;
  end

  // Protection flops
  // Reset leaves the element cold with no heat
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_reg <= 32'h0;
      tick_reg <= 1'b0;
      imax_reg <= 16'h0;
      heat_reg <= 56'h0;
      state_reg <= st_cold;
      warn_reg <= 1'b0;
      idmt_reg <= 1'b0;
      shut_reg <= 1'b0;
      elec_reg <= 1'b0;
      over_reg <= 1'b0;
      evt_reg <= 3'h0;
    end else begin
      // Register the whole protection state together
      tick_cnt_reg <= tick_cnt_next;
      tick_reg <= tick_next;
      imax_reg <= imax_next;
      heat_reg <= heat_next;
      state_reg <= state_next;
      warn_reg <= warn_next;
      idmt_reg <= idmt_next;
      shut_reg <= shut_next;
      elec_reg <= elec_next;
      over_reg <= over_next;
      evt_reg <= evt_next;
    end
  end

  // Outputs straight from flops
  // No logic between these registers and the pins
  // Each one is a single flip-flop, glitch free at the pin
  assign bus_rdata = rdata_reg;
  assign warn_alarm = warn_reg;
  assign idmt_alarm = idmt_reg;
  assign shutdown_out = shut_reg;
  assign elec_trip_out = elec_reg;
  assign irq = irq_reg;
endmodule

/* File: hdl/overcurrent_pkg.sv */
// Types shared by the over-current protection logic
package overcurrent_pkg;
  // Phase current, trip level and multiplier word
  typedef logic [15:0] amps_t;
  // Thermal accumulator word
  typedef logic [55:0] heat_t;
  // Control register fields, warn_en in bit 0
  typedef struct packed {
    logic action;
    logic latch_all;
    logic idmt_en;
    logic warn_en;
  } ctrl_s;
  // Event and status bits, warn in bit 0
  typedef struct packed {
    logic over;
    logic idmt;
    logic warn;
  } evt_s;
  // Thermal element states
  typedef enum logic [1:0] {
    st_cold,
    st_heat,
    st_cool,
    st_tripped
  } heat_e;
endpackage

/* File: hdl/overcurrent_regs.svh */
// Register map, reset values and timing constants of the over-current protection
`ifndef OVERCURRENT_REGS_SVH
`define OVERCURRENT_REGS_SVH
`define ADDR_W 8
`define OFS_CTRL 8'h00
`define OFS_TRIP 8'h04
`define OFS_TMUL 8'h08
`define OFS_STATUS 8'h0c
`define OFS_MASK 8'h10
`define OFS_STATE 8'h14
`define OFS_HEAT 8'h18
`define CTRL_CLEAR_BIT 4
`define RST_CTRL 4'hb
`define RST_TRIP 16'h01f4
`define RST_TMUL 16'h0168
`define RST_MASK 3'h7
`define HEAT_RD_LSB 24
`define COOL_SHIFT 9
`define CLK_PERIOD_NS 40
`define TICK_NS 10000000
`define TMUL_UNIT_NS 100000000
`endif

/* File: verif/overcurrent_idmt_protection_bench.sv */
// Self-checking bench for the over-current protection
`timescale 1ns/1ps
`include "overcurrent_regs.svh"
module overcurrent_idmt_protection_bench;
  import overcurrent_pkg::*;
  // Row: load, loaded phase, multiplier, action, ticks to trip
  typedef struct packed {
    amps_t load;
    logic [1:0] hot;
    amps_t tmul;
    logic act;
    logic [7:0] ticks;
  } row_s;
  localparam int TK = 4; // Shortened time base
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  amps_t load = 16'h0;
  logic [1:0] hot = 2'h0;
  amps_t phase_line_a, phase_line_b, phase_line_c;
  logic [31:0] bus_rdata;
  logic warn_alarm, idmt_alarm, shutdown_out, elec_trip_out, irq;
  int miscompares = 0;
  int compares = 0;
  int cyc = 0; // Timeout counter
  int n; // Cycles to trip
  row_s rows [4];
  always #20 ref_clk = ~ref_clk;
  phase_source phase_source_inst (.load(load), .hot(hot), .phase_line_a(phase_line_a),
    .phase_line_b(phase_line_b), .phase_line_c(phase_line_c));
  overcurrent_idmt_protection #(.TICK_CYCLES(TK)) overcurrent_idmt_protection_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .phase_line_a(phase_line_a), .phase_line_b(phase_line_b),
    .phase_line_c(phase_line_c), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .warn_alarm(warn_alarm), .idmt_alarm(idmt_alarm),
    .shutdown_out(shutdown_out), .elec_trip_out(elec_trip_out), .irq(irq));
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One-cycle register write
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask
  // Read and compare the following cycle
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1 chk(bus_rdata, exp);
  endtask
  // Bounded wait for the thermal alarm
  task wait_trip();
    n = 0;
    while (idmt_alarm !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask
  // Counts and verdict
  task summarize();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    rows = '{'{16'h03e8, 2'h0, 16'h0001, 1'b1, 8'h0a}, '{16'h05dc, 2'h1, 16'h0001, 1'b0, 8'h03},
      '{16'h03e8, 2'h2, 16'h0002, 1'b1, 8'h14}, '{16'h02ee, 2'h1, 16'h0001, 1'b0, 8'h28}};
    repeat (16) @(posedge ref_clk);
    chk({warn_alarm, idmt_alarm, shutdown_out, elec_trip_out, irq}, 32'h0);
    reset_n <= 1'b1;
    rdc(`OFS_CTRL, 32'hb);
    rdc(`OFS_TRIP, 32'h1f4);
    rdc(`OFS_TMUL, 32'h168);
    rdc(`OFS_MASK, 32'h7);
    rdc(8'h20, 32'h0);
    $display("reset done");
    @(posedge ref_clk);
    hot <= 2'h1;
    load <= 16'h01f3;
    repeat (3) @(posedge ref_clk);
    #1 chk(warn_alarm, 32'h0);
    @(posedge ref_clk);
    load <= 16'h01f4;
    repeat (2) @(posedge ref_clk);
    #1 chk(warn_alarm, 32'h1);
    repeat (2) @(posedge ref_clk);
    #1 chk(irq, 32'h1);
    rdc(`OFS_STATUS, 32'h1);
    repeat (2) @(posedge ref_clk);
    #1 chk(irq, 32'h0);
    @(posedge ref_clk);
    load <= 16'h01f3;
    repeat (2) @(posedge ref_clk);
    #1 chk(warn_alarm, 32'h0);
    wr(`OFS_MASK, 32'h0);
    load <= 16'h0258;
    repeat (4) @(posedge ref_clk);
    #1 chk(irq, 32'h0);
    rdc(`OFS_STATUS, 32'h5);
    $display("warning done");
    wr(`OFS_CTRL, 32'h7);
    load <= 16'h0;
    repeat (4) @(posedge ref_clk);
    #1 chk(warn_alarm, 32'h1);
    wr(`OFS_CTRL, 32'h17);
    repeat (3) @(posedge ref_clk);
    #1 chk(warn_alarm, 32'h0);
    wr(`OFS_TMUL, 32'h1);
    wr(`OFS_CTRL, 32'h1);
    load <= 16'h05dc;
    repeat (60) @(posedge ref_clk);
    #1 chk(idmt_alarm, 32'h0);
    wr(`OFS_CTRL, 32'h0);
    repeat (4) @(posedge ref_clk);
    #1 chk(warn_alarm, 32'h0);
    $display("latch and enable done");
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_CTRL, 32'h1);
      load <= 16'h0;
      wr(`OFS_TMUL, {16'h0, rows[i].tmul});
      wr(`OFS_CTRL, rows[i].act ? 32'hb : 32'h3);
      hot <= rows[i].hot;
      load <= rows[i].load;
      wait_trip();
      #1 chk(32'(n >= (rows[i].ticks - 1) * TK && n <= rows[i].ticks * TK + 8), 32'h1);
      chk({shutdown_out, elec_trip_out}, rows[i].act ? 2'h1 : 2'h2);
      $display("row %0d done", i);
    end
    wr(`OFS_CTRL, 32'h1);
    load <= 16'h0;
    wr(`OFS_CTRL, 32'h3);
    load <= 16'h03e8;
    repeat (20) @(posedge ref_clk);
    load <= 16'h0;
    repeat (8) @(posedge ref_clk);
    load <= 16'h03e8;
    wait_trip();
    #1 chk(32'(n < 32), 32'h1);
    $display("cooling done");
    rdc(`OFS_STATE, 32'h1f);
    wr(`OFS_CTRL, 32'h13);
    @(posedge ref_clk);
    #1 chk(idmt_alarm, 32'h0);
    wait_trip();
    #1 chk(32'(n <= 8), 32'h1);
    $display("clear and retrip done");
    @(posedge ref_clk);
    reset_n <= 1'b0;
    load <= 16'h0;
    repeat (2) @(posedge ref_clk);
    #1 chk({warn_alarm, idmt_alarm, shutdown_out, elec_trip_out, irq}, 32'h0);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    rdc(`OFS_TMUL, 32'h168);
    rdc(`OFS_STATE, 32'h0);
    $display("mid-run reset done");
    summarize();
  end
endmodule

/* File: verif/overcurrent_idmt_protection_sva.sv */
// Checker for the over-current protection ports
`timescale 1ns/1ps
`include "overcurrent_regs.svh"
module overcurrent_idmt_protection_sva
  import overcurrent_pkg::*;
#(
  parameter int TICK_CYCLES = 4
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire overcurrent_pkg::amps_t phase_line_a,
  input wire overcurrent_pkg::amps_t phase_line_b,
  input wire overcurrent_pkg::amps_t phase_line_c,
  input wire logic [`ADDR_W-1:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic warn_alarm,
  input wire logic idmt_alarm,
  input wire logic shutdown_out,
  input wire logic elec_trip_out,
  input wire logic irq
);
  amps_t trip; // Shadow trip level
  logic [3:0] ctrl; // Shadow control bits
  amps_t imax; // Highest phase
  logic hi, lo; // Quiet above or below trip
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Highest phase and quiet-bus qualifiers
  always_comb begin
    imax = phase_line_a;
    if (phase_line_b > imax) imax = phase_line_b;
    if (phase_line_c > imax) imax = phase_line_c;
    hi = imax >= trip && ctrl[0] && !bus_wr;
    lo = imax < trip && !ctrl[2] && !bus_wr;
  end
  // Shadows follow bus writes
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      trip <= `RST_TRIP;
      ctrl <= `RST_CTRL;
    end else if (bus_wr && bus_addr == `OFS_TRIP) begin
      trip <= bus_wdata[15:0];
    end else if (bus_wr && bus_addr == `OFS_CTRL) begin
      ctrl <= bus_wdata[3:0];
    end
  end
  a_warn_rise: assert property (hi [*3] |=> warn_alarm) else $error("warning missing");
  a_warn_fall: assert property (lo [*3] |=> !warn_alarm) else $error("warning stuck");
  a_warn_off: assert property ((!ctrl[0] && !bus_wr) [*3] |=> !warn_alarm) else $error("warn off");
  a_idmt_off: assert property ((!ctrl[1] && !bus_wr) [*3] |=> !idmt_alarm) else $error("trip off");
  a_action_one: assert property (!(shutdown_out && elec_trip_out)) else $error("two actions");
  a_action_src: assert property (shutdown_out || elec_trip_out |-> idmt_alarm || $past(idmt_alarm))
    else $error("action without alarm");
  a_rd_idle: assert property (!bus_rd |=> bus_rdata == 32'h0) else $error("read data idle");
  a_rd_trip: assert property (bus_rd && bus_addr == `OFS_TRIP |=> bus_rdata == {16'h0, trip})
    else $error("trip readback");
  c_trip: cover property ($rose(idmt_alarm));
  c_warn: cover property ($rose(warn_alarm));
  c_irq: cover property ($rose(irq));
endmodule
bind overcurrent_idmt_protection overcurrent_idmt_protection_sva #(.TICK_CYCLES(TICK_CYCLES)) sva_inst (
  .ref_clk(ref_clk), .reset_n(reset_n), .phase_line_a(phase_line_a), .phase_line_b(phase_line_b),
  .phase_line_c(phase_line_c), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_rdata(bus_rdata), .warn_alarm(warn_alarm), .idmt_alarm(idmt_alarm),
  .shutdown_out(shutdown_out), .elec_trip_out(elec_trip_out), .irq(irq));

/* File: verif/phase_source.sv */
// Generator phase current measurement model
`timescale 1ns/1ps
module phase_source
  import overcurrent_pkg::*;
(
  input wire overcurrent_pkg::amps_t load,
  input wire logic [1:0] hot,
  output overcurrent_pkg::amps_t phase_line_a,
  output overcurrent_pkg::amps_t phase_line_b,
  output overcurrent_pkg::amps_t phase_line_c
);
  // Loaded phase carries full current, the others half
  always_comb begin
    phase_line_a = (hot == 2'h0) ? load : load >> 1;
    phase_line_b = (hot == 2'h1) ? load : load >> 1;
    phase_line_c = (hot == 2'h2) ? load : load >> 1;
  end
endmodule
